// *** rtl/pfc_seq.sv ***
/*
  Function check sequencer: interval timer, manual trigger, receiver swivel,
  control value checks, analog output selection, wear counting.
  Assumes live readings arrive synchronously to core_clk from the sensing head
  logic; the manual trigger and maintenance switch are pins and are synchronised.
*/
// Function
// - Automatic checks start at a configurable interval, timed from power-on.
// - Manual checks are accepted; deviations in any check raise errors.
// - Receiver swivels to control position and back; measures contamination, zero, span.
// - Control determination phase is budgeted for up to sixty seconds.
// - Contamination output scales from live zero to 20 mA at 40 percent.
// - Span then zero control values are output between live zero and 20 mA.
// - Analog output holds the last process value during determination.
// - Control values go out only if enabled, else live value (error current on malfunction) resumes.
// - Display indication stands for the whole check.
// - Maintenance mode blocks automatic check starts.
// - A new interval takes effect only after the pending start.
// - Completed checks are counted; warning at 12000, error at 15000.
// - Contamination correction factor derived from transmission and reference.
// - Span measuring versus monitor deviation beyond two percent is an error.
// - Span error stays until the next successful check completes.
// - Sender off for zero check; out-of-range zero is an error.
`timescale 1ns/1ns
module pfc_seq (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic manual_req_pin,
  input wire logic maint_pin,
  input wire logic [31:0] interval_s,
  input wire logic ctrl_out_en,
  input wire logic [9:0] error_current,
  input wire logic [9:0] process_val,
  input wire logic [9:0] transmission,
  input wire logic [9:0] trans_ref,
  input wire pfc_pkg::pfc_ctrl_vals_type ctrl_vals,
  output logic swivel_ctrl_pos,
  output logic sender_off,
  output logic sender_70pct,
  output logic check_display,
  output logic [9:0] analog_out,
  output logic [9:0] corr_factor,
  output pfc_pkg::pfc_status_type status,
  output logic [15:0] cycle_count
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic man_s1_r, man_s2_r, man_s3_r, mnt_s1_r, mnt_s2_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      man_s1_r <= 1'b0;
      man_s2_r <= 1'b0;
      man_s3_r <= 1'b0;
      mnt_s1_r <= 1'b0;
      mnt_s2_r <= 1'b0;
    end else if (clk_en) begin
      man_s1_r <= manual_req_pin;
      man_s2_r <= man_s1_r;
      man_s3_r <= man_s2_r;
      mnt_s1_r <= maint_pin;
      mnt_s2_r <= mnt_s1_r;
    end
  end
  logic manual_rise;
  assign manual_rise = man_s2_r & ~man_s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interval timer, running from reset release (power-on).
  pfc_pkg::pfc_state_type state_r;
  logic [31:0] sub_r, sec_r, ival_r;
  logic auto_due, start;
  assign auto_due = (sec_r >= ival_r) && (ival_r != 32'h0);
  // Maintenance suppresses only automatic starts; the due start waits.
  assign start = (state_r == pfc_pkg::PFC_IDLE) &&
                 (manual_rise || (auto_due && !mnt_s2_r));

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sub_r <= 32'h0;
      sec_r <= 32'h0;
      ival_r <= pfc_pkg::INTERVAL_S_DEF;
    end else if (clk_en) begin
      if (auto_due && start) begin
        sub_r <= 32'h0;
        sec_r <= 32'h0;
        ival_r <= interval_s;
      end else if (!auto_due) begin
        if (sub_r == pfc_pkg::ONE_S_CYC - 32'h1) begin
          sub_r <= 32'h0;
          sec_r <= sec_r + 32'h1;
        end else begin
          sub_r <= sub_r + 32'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  logic [31:0] tmr_r;
  logic [9:0] held_r;
  logic [9:0] c_contam_r, c_span_r, c_zero_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= pfc_pkg::PFC_IDLE;
      tmr_r <= 32'h0;
      held_r <= 10'h0;
      c_contam_r <= 10'h0;
      c_span_r <= 10'h0;
      c_zero_r <= 10'h0;
    end else if (clk_en) begin
      case (state_r)
        pfc_pkg::PFC_IDLE: begin
          tmr_r <= 32'h0;
          held_r <= process_val;
          if (start) begin
            state_r <= pfc_pkg::PFC_SWING;
          end
        end
        pfc_pkg::PFC_SWING: begin
          tmr_r <= tmr_r + 32'h1;
          if (ctrl_vals.done || tmr_r >= pfc_pkg::CTRL_PHASE_CYC - 32'h1) begin
            c_contam_r <= ctrl_vals.contam;
            c_span_r <= ctrl_vals.span_meas;
            c_zero_r <= ctrl_vals.zero;
            tmr_r <= 32'h0;
            state_r <= ctrl_out_en ? pfc_pkg::PFC_OUT_CONT : pfc_pkg::PFC_IDLE;
          end
        end
        pfc_pkg::PFC_OUT_CONT, pfc_pkg::PFC_OUT_SPAN, pfc_pkg::PFC_OUT_ZERO: begin
          if (tmr_r >= pfc_pkg::OUT_STEP_CYC - 32'h1) begin
            tmr_r <= 32'h0;
            case (state_r)
              pfc_pkg::PFC_OUT_CONT: state_r <= pfc_pkg::PFC_OUT_SPAN;
              pfc_pkg::PFC_OUT_SPAN: state_r <= pfc_pkg::PFC_OUT_ZERO;
              default: state_r <= pfc_pkg::PFC_IDLE;
            endcase
          end else begin
            tmr_r <= tmr_r + 32'h1;
          end
        end
        default: state_r <= pfc_pkg::PFC_IDLE;
      endcase
    end
  end

  logic det_end;
  assign det_end = (state_r == pfc_pkg::PFC_SWING) &&
                   (ctrl_vals.done || tmr_r >= pfc_pkg::CTRL_PHASE_CYC - 32'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Evaluation of control values at the end of determination.
  logic [19:0] span_prod, mon_lo, mon_hi;
  logic span_bad, zero_bad, contam_bad;
  assign span_prod = 20'(ctrl_vals.span_meas) * 20'd1000;
  assign mon_lo = 20'(ctrl_vals.span_mon) * 20'(pfc_pkg::SPAN_NOM_PM - pfc_pkg::SPAN_TOL_PM);
  assign mon_hi = 20'(ctrl_vals.span_mon) * 20'(pfc_pkg::SPAN_NOM_PM + pfc_pkg::SPAN_TOL_PM);
  assign span_bad = (span_prod < mon_lo) || (span_prod > mon_hi);
  assign zero_bad = ctrl_vals.zero > pfc_pkg::ZERO_MAX;
  assign contam_bad = ctrl_vals.contam >= pfc_pkg::CONTAM_LIMIT;

  // The count saturates, so the wear flags compare the saturated value; a bare
  // increment would wrap to zero at the top and drop both flags.
  logic [15:0] count_nxt;
  assign count_nxt = (cycle_count != 16'hffff) ? cycle_count + 16'h1 : cycle_count;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status <= '0;
      cycle_count <= 16'h0;
    end else if (clk_en && det_end) begin
      // Span, zero and contamination errors are re-evaluated each check, so a clean check clears them.
      status.span_err <= span_bad;
      status.zero_err <= zero_bad;
      status.malfunction <= contam_bad;
      cycle_count <= count_nxt;
      status.wear_warn <= count_nxt >= pfc_pkg::WEAR_WARN_CNT;
      status.wear_err <= count_nxt >= pfc_pkg::WEAR_ERR_CNT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Contamination correction: factor = ref * 512 / transmission.
  // A factor beyond the 10-bit range is clipped rather than wrapped.
  logic [18:0] corr_q;
  assign corr_q = {trans_ref, 9'h0} / {9'h0, transmission};
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      corr_factor <= 10'h200;
    end else if (clk_en && det_end && transmission != 10'h0) begin
      corr_factor <= (corr_q > 19'h003ff) ? 10'h3ff : corr_q[9:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scaling onto live zero .. 20 mA.
  function automatic logic [9:0] scale(input logic [9:0] v, input logic [9:0] fs);
    logic [19:0] num;
    num = 20'(v) * 20'(pfc_pkg::MA20_CODE - pfc_pkg::LIVE_ZERO_CODE);
    if (v >= fs) begin
      scale = pfc_pkg::MA20_CODE;
    end else begin
      scale = pfc_pkg::LIVE_ZERO_CODE + 10'(num / 20'(fs));
    end
  endfunction

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      analog_out <= pfc_pkg::LIVE_ZERO_CODE;
      swivel_ctrl_pos <= 1'b0;
      sender_off <= 1'b0;
      sender_70pct <= 1'b0;
      check_display <= 1'b0;
    end else if (clk_en) begin
      swivel_ctrl_pos <= state_r == pfc_pkg::PFC_SWING;
      sender_70pct <= (state_r == pfc_pkg::PFC_SWING) && tmr_r[24];
      sender_off <= (state_r == pfc_pkg::PFC_SWING) && tmr_r[25];
      check_display <= state_r != pfc_pkg::PFC_IDLE;
      case (state_r)
        pfc_pkg::PFC_SWING: analog_out <= held_r;
        pfc_pkg::PFC_OUT_CONT: analog_out <= scale(c_contam_r, pfc_pkg::CONTAM_LIMIT);
        pfc_pkg::PFC_OUT_SPAN: analog_out <= scale(c_span_r, pfc_pkg::FULL_SCALE);
        pfc_pkg::PFC_OUT_ZERO: analog_out <= scale(c_zero_r, pfc_pkg::FULL_SCALE);
        default: analog_out <= status.malfunction ? error_current : process_val;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  maint_block_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && mnt_s2_r && !manual_rise && state_r == pfc_pkg::PFC_IDLE)
    |=> state_r == pfc_pkg::PFC_IDLE) else $error("auto check during maintenance");
  hold_out_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && state_r == pfc_pkg::PFC_SWING) |=> analog_out == $past(held_r))
    else $error("output not held");
  display_on_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && state_r != pfc_pkg::PFC_IDLE) |=> check_display)
    else $error("display missing in check");
  no_ctrl_out_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && det_end && !ctrl_out_en) |=> state_r == pfc_pkg::PFC_IDLE)
    else $error("control values output while disabled");
  phase_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
    tmr_r <= pfc_pkg::OUT_STEP_CYC) else $error("phase timer overrun");
  count_step_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && det_end && cycle_count < 16'hffff) |=> cycle_count == $past(cycle_count) + 16'h1)
    else $error("cycle not counted");
  span_err_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && det_end) |=> status.span_err == $past(span_bad))
    else $error("span error wrong");
  malf_out_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && state_r == pfc_pkg::PFC_IDLE && status.malfunction)
    |=> analog_out == $past(error_current))
    else $error("error current missing");
  swivel_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && start) |=> ##1 (swivel_ctrl_pos || !clk_en))
    else $error("receiver not swivelled");
  sender_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (sender_off || sender_70pct) |-> swivel_ctrl_pos)
    else $error("sender changed outside control position");

endmodule

// *** inc/pfc_pkg.sv ***
/*
  Package for the function check sequencer: timing counts, scaling constants,
  check limits, sequencer states and the carrier structs for sensor readings
  and check status flags.
  Assumes a 20 MHz core clock; readings are 10-bit codes from the sensing head.
*/
package pfc_pkg;

  localparam int CLK_HZ = 20000000;
  // Control value determination takes roughly 40 s to 60 s; the phase budget is 60 s.
  localparam int CTRL_PHASE_S = 60;
  localparam longint CTRL_PHASE_CYC_L = longint'(CTRL_PHASE_S) * longint'(CLK_HZ);
  localparam logic [31:0] CTRL_PHASE_CYC = CTRL_PHASE_CYC_L[31:0];
  // Each output step of the control values stands this long.
  localparam int OUT_STEP_S = 90;
  localparam longint OUT_STEP_CYC_L = longint'(OUT_STEP_S) * longint'(CLK_HZ);
  localparam logic [31:0] OUT_STEP_CYC = OUT_STEP_CYC_L[31:0];
  // Default check interval in seconds (8 h).
  localparam logic [31:0] INTERVAL_S_DEF = 32'h0000_7080;
  localparam logic [31:0] ONE_S_CYC = 32'(CLK_HZ);

  localparam logic [15:0] WEAR_WARN_CNT = 16'h2ee0;
  localparam logic [15:0] WEAR_ERR_CNT = 16'h3a98;

  // Readings are 10-bit codes with full scale 0x3ff.
  localparam int DW = 10;
  // 40 % contamination of full scale (0x3ff * 0.4).
  localparam logic [DW-1:0] CONTAM_LIMIT = 10'h199;
  localparam logic [DW-1:0] FULL_SCALE = 10'h3ff;
  // Span ratio 70 % expressed as per mille, and the +-2 % tolerance.
  localparam logic [9:0] SPAN_NOM_PM = 10'h2bc;
  localparam logic [9:0] SPAN_TOL_PM = 10'h014;
  localparam logic [DW-1:0] ZERO_MAX = 10'h010;

  // Output current codes: live zero and 20 mA on the 10-bit current DAC.
  localparam logic [DW-1:0] LIVE_ZERO_CODE = 10'h0cd;
  localparam logic [DW-1:0] MA20_CODE = 10'h3ff;

  typedef enum logic [2:0] {
    PFC_IDLE = 3'b000,
    PFC_SWING = 3'b001,
    PFC_OUT_CONT = 3'b010,
    PFC_OUT_SPAN = 3'b011,
    PFC_OUT_ZERO = 3'b100
  } pfc_state_type;

  typedef struct packed {
    logic [DW-1:0] contam;
    logic [DW-1:0] span_meas;
    logic [DW-1:0] span_mon;
    logic [DW-1:0] zero;
    logic done;
  } pfc_ctrl_vals_type;

  typedef struct packed {
    logic malfunction;
    logic span_err;
    logic zero_err;
    logic wear_warn;
    logic wear_err;
  } pfc_status_type;

endpackage

// *** dv/pfc_head_model.sv ***
/*
  Behavioural sensing head for the function check sequencer bench.
  Assumes the sequencer holds swivel_ctrl_pos high while the receiver is in
  control position; the bench chooses the readings and a prompt or slow answer.
*/
`timescale 1ns/1ns
module pfc_head_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic swivel_ctrl_pos,
  input wire logic slow,
  input wire pfc_pkg::pfc_ctrl_vals_type want,
  output pfc_pkg::pfc_ctrl_vals_type ctrl_vals
);
  logic [7:0] wait_r;

  // Outside the report cycle the readings toggle every cycle, so that a stale
  // value can never be mistaken for a valid one.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wait_r <= 8'h00;
      ctrl_vals <= '0;
    end else begin
      wait_r <= !swivel_ctrl_pos ? 8'h00 : (wait_r == 8'hff ? wait_r : wait_r + 8'h01);
      if (swivel_ctrl_pos && wait_r == (slow ? 8'h3c : 8'h03)) begin
        ctrl_vals <= '{want.contam, want.span_meas, want.span_mon, want.zero, 1'b1};
      end else begin
        ctrl_vals <= '{~ctrl_vals.contam, ~ctrl_vals.span_meas, ~ctrl_vals.span_mon,
                       ~ctrl_vals.zero, 1'b0};
      end
    end
  end
endmodule

// *** dv/pfc_seq_tb.sv ***
/*
  Self-checking bench for the function check sequencer.
  Assumes pfc_pkg and pfc_seq are compiled first and the head model drives readings.
*/
`timescale 1ns/1ns
module pfc_seq_tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic manual_req_pin = 1'b0;
  logic maint_pin = 1'b0;
  logic ctrl_out_en = 1'b0;
  logic slow = 1'b0;
  logic [9:0] error_current = 10'h000;
  logic [9:0] process_val = 10'h000;
  logic [9:0] trans_ref = 10'h100;
  pfc_pkg::pfc_ctrl_vals_type ctrl_vals;
  pfc_pkg::pfc_ctrl_vals_type want = '0;
  logic swivel_ctrl_pos, sender_off, sender_70pct, check_display;
  logic [9:0] analog_out, corr_factor;
  pfc_pkg::pfc_status_type status;
  logic [15:0] cycle_count;
  int failures = 0;
  int checks = 0;
  logic [15:0] nchk = 16'h0000;
  typedef struct {int id; logic [15:0] exp;} pfc_note_type;
  pfc_note_type notes[$];
  pfc_note_type cur;
  event look;
  string nms[10] = '{"analog_out", "check_display", "span_err", "zero_err",
                     "malfunction", "cycle_count", "corr_factor", "swivel_ctrl_pos",
                     "sender_off", "sender_70pct"};

  always #25 core_clk = ~core_clk;

  pfc_seq dut (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1),
    .manual_req_pin(manual_req_pin), .maint_pin(maint_pin), .interval_s(32'h0000_0000),
    .ctrl_out_en(ctrl_out_en), .error_current(error_current), .process_val(process_val),
    .transmission(10'h200), .trans_ref(trans_ref), .ctrl_vals(ctrl_vals),
    .swivel_ctrl_pos(swivel_ctrl_pos), .sender_off(sender_off), .sender_70pct(sender_70pct),
    .check_display(check_display), .analog_out(analog_out), .corr_factor(corr_factor),
    .status(status), .cycle_count(cycle_count));

  pfc_head_model head (.core_clk(core_clk), .resetn(resetn), .swivel_ctrl_pos(swivel_ctrl_pos),
    .slow(slow), .want(want), .ctrl_vals(ctrl_vals));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] seen(input int id);
    case (id)
      0: return 16'(analog_out);
      1: return 16'(check_display);
      2: return 16'(status.span_err);
      3: return 16'(status.zero_err);
      4: return 16'(status.malfunction);
      5: return cycle_count;
      6: return 16'(corr_factor);
      7: return 16'(swivel_ctrl_pos);
      8: return 16'(sender_off);
      default: return 16'(sender_70pct);
    endcase
  endfunction

  always @(look) begin
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      checks++;
      if (seen(cur.id) !== cur.exp) begin
        failures++;
        $display("[ERR] %s expected %h seen %h", nms[cur.id], cur.exp, seen(cur.id));
      end
    end
  end

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic note(input int id, input logic [15:0] e);
    notes.push_back('{id, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Every wait is bounded; running out counts as a mismatch and ends the run.
  task automatic wait_for(input int id, input logic [15:0] v);
    int i;
    for (i = 0; i < 400 && seen(id) !== v; i++) begin
      @(negedge core_clk);
    end
    if (i == 400) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nms[id], v, seen(id));
      test_done();
    end
  endtask

  task automatic run(input logic [9:0] c, m, mo, z, input logic sp, ze, mf, sl);
    logic [9:0] held;
    want = '{c, m, mo, z, 1'b0};
    slow = sl;
    held = process_val;
    // With transmission at 512 the factor equals the reference itself.
    trans_ref = 10'($urandom);
    manual_req_pin = 1'b1;
    wait_for(1, 16'h0001);
    process_val = 10'($urandom);
    cyc(2);
    note(7, 16'h0001);
    note(0, 16'(held));
    note(8, 16'h0000);
    note(9, 16'h0000);
    -> look;
    manual_req_pin = 1'b0;
    nchk = nchk + 16'h0001;
    wait_for(1, 16'h0000);
    cyc(2);
    note(7, 16'h0000);
    note(2, 16'(sp));
    note(3, 16'(ze));
    note(4, 16'(mf));
    note(5, nchk);
    note(6, 16'(trans_ref));
    note(0, mf ? 16'(error_current) : 16'(process_val));
    -> look;
    cyc(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(86));
    process_val = 10'($urandom);
    error_current = 10'($urandom);
    cyc(3);
    note(0, 16'h00cd);
    note(6, 16'h0200);
    note(5, 16'h0000);
    note(1, 16'h0000);
    -> look;
    resetn = 1'b1;
    cyc(3);
    // A clean span reading is 70 % of the monitor channel: 0x166 against 0x200.
    run(10'h000, 10'h166, 10'h200, 10'h000, 1'b0, 1'b0, 1'b0, 1'b0);
    run(10'h000, 10'h100, 10'h200, 10'h000, 1'b1, 1'b0, 1'b0, 1'b1);
    // Maintenance mode only blocks automatic starts, so a manual one still runs.
    maint_pin = 1'b1;
    run(10'h000, 10'h100, 10'h200, 10'h3ff, 1'b1, 1'b1, 1'b0, 1'b0);
    maint_pin = 1'b0;
    run(10'h000, 10'h166, 10'h200, 10'h000, 1'b0, 1'b0, 1'b0, 1'b1);
    run(10'h3ff, 10'h166, 10'h200, 10'h000, 1'b0, 1'b0, 1'b1, 1'b0);
    ctrl_out_en = 1'b1;
    want = '{10'h0cc, 10'h166, 10'h200, 10'h000, 1'b0};
    manual_req_pin = 1'b1;
    wait_for(1, 16'h0001);
    manual_req_pin = 1'b0;
    wait_for(5, nchk + 16'h0001);
    cyc(2);
    note(1, 16'h0001);
    // 204 of the 409 limit codes lift live zero by 408 of its 818 codes to 20 mA.
    note(0, 16'h0265);
    -> look;
    cyc(1);
    test_done();
  end
endmodule
